// File: pkg/serial_rx_pkg.sv
// How it works
// - a falling edge on the line starts a character; start bit is zero
// - half a bit later recheck; if high, abandon silently and rearm
// - step one bit time per data bit, majority decide, shift into shift register
// - stop bit sampled one bit after last data; low sets framing error
// - completed character goes into fifo and pending flag rises
// - reading data register returns oldest character and pops it
// - pending flag is high when enabled and fifo not empty; not writable
// - interrupt only when all three enables and pending flag are set
// - every fifo entry keeps its own framing tag; status shows oldest
// - framing status is read-only, blocks nothing, raises no interrupt
// - port enable clear resets framing status; receive enable clear keeps it
// - if all entries have framing errors, status stays set until the last one is read
// - fifo holds two; a third complete character sets overrun unless a data read pops in that cycle, which drops it
// - on overrun, fifo stays readable, nothing accepted; cleared by enable clears
// - nine-bit mode shifts nine bits; ninth bit of oldest shown in status
// - address detect in nine-bit mode keeps only ninth-bit-set characters, drops the rest; in eight-bit mode it keeps all
// - in nine-bit address detect mode delivered characters show ninth bit set
// - bit recovery runs on sixteen-times-baud tick; shift once per bit
// - port enable clear holds port in reset and releases line pins
package serial_rx_pkg;
  localparam logic [2:0] addr_rx_status = 3'h0;
  localparam logic [2:0] addr_rx_data = 3'h1;
  localparam logic [2:0] addr_tx_status = 3'h2;
  localparam logic [2:0] addr_baud_ctrl = 3'h3;
  localparam logic [2:0] addr_baud_low = 3'h4;
  localparam logic [2:0] addr_baud_high = 3'h5;
  localparam logic [2:0] addr_int_ctrl = 3'h6;

  localparam int bit_port_enable = 7;
  localparam int bit_nine_sel = 6;
  localparam int bit_rx_enable = 4;
  localparam int bit_addr_detect = 3;
  localparam int bit_framing = 2;
  localparam int bit_overrun = 1;
  localparam int bit_ninth = 0;
  localparam int bit_sync_mode = 4;
  localparam int bit_high_baud = 2;
  localparam int bit_wide_baud = 3;
  localparam int bit_rx_idle = 6;
  localparam int bit_global_ie = 2;
  localparam int bit_periph_ie = 1;
  localparam int bit_rx_ie = 0;

  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] baud_reset = 8'h00;
  localparam logic [3:0] oversample = 4'hf;
  localparam logic [3:0] half_bit = 4'h7;
  localparam logic [3:0] centre_early = 4'h6;
  localparam logic [3:0] centre_late = 4'h8;
  localparam int fifo_depth = 2;

  typedef enum logic [1:0] {st_idle, st_start, st_data, st_stop} rx_state_t;

  typedef struct packed {
    logic framing;
    logic [8:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_t;
endpackage : serial_rx_pkg

// File: logic/async_serial_receiver.sv
`timescale 1ns/1ps
module async_serial_receiver (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire serial_rx_pkg::reg_req_t req,
  output logic [7:0] rdata,
  // line
  input wire logic serial_receive_pin,
  output logic pin_serial_owned,
  // interrupt
  output logic receive_interrupt
);
  // =====================================================
  // registers
  logic [7:0] rcs_reg;
  logic [7:0] txs_reg;
  logic [7:0] baud_reg;
  logic [7:0] div_low_reg;
  logic [7:0] div_high_reg;
  logic [2:0] ie_reg;
  logic port_en;
  logic rx_en;
  logic nine_sel;
  logic addr_det;
  logic data_pop;

  assign port_en = rcs_reg[serial_rx_pkg::bit_port_enable];
  assign rx_en = rcs_reg[serial_rx_pkg::bit_rx_enable] & port_en
    & ~txs_reg[serial_rx_pkg::bit_sync_mode];
  assign nine_sel = rcs_reg[serial_rx_pkg::bit_nine_sel];
  assign addr_det = rcs_reg[serial_rx_pkg::bit_addr_detect] & nine_sel;
  assign data_pop = req.read && req.addr == serial_rx_pkg::addr_rx_data;
  assign pin_serial_owned = port_en;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rcs_reg <= serial_rx_pkg::ctrl_reset;
      txs_reg <= serial_rx_pkg::ctrl_reset;
      baud_reg <= serial_rx_pkg::ctrl_reset;
      div_low_reg <= serial_rx_pkg::baud_reset;
      div_high_reg <= serial_rx_pkg::baud_reset;
      ie_reg <= 3'h0;
    end else if (req.write) begin
      if (req.addr == serial_rx_pkg::addr_rx_status) begin
        rcs_reg <= {req.wdata[7:3], 3'h0};
      end else if (req.addr == serial_rx_pkg::addr_tx_status) begin
        txs_reg <= req.wdata;
      end else if (req.addr == serial_rx_pkg::addr_baud_ctrl) begin
        baud_reg <= req.wdata;
      end else if (req.addr == serial_rx_pkg::addr_baud_low) begin
        div_low_reg <= req.wdata;
      end else if (req.addr == serial_rx_pkg::addr_baud_high) begin
        div_high_reg <= req.wdata;
      end else if (req.addr == serial_rx_pkg::addr_int_ctrl) begin
        ie_reg <= req.wdata[2:0];
      end
    end
  end

  // =====================================================
  // baud tick generator, sixteen ticks per bit
  logic [15:0] div_value;
  logic [15:0] div_cnt_reg;
  logic tick;

  always_comb begin
    div_value = {div_high_reg, div_low_reg};
    if (!baud_reg[serial_rx_pkg::bit_wide_baud]) begin
      div_value = {8'h00, div_low_reg};
    end
  end
  assign tick = (div_cnt_reg == 16'h0000);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_cnt_reg <= 16'h0000;
    end else if (!port_en || tick) begin
      div_cnt_reg <= div_value;
    end else begin
      div_cnt_reg <= div_cnt_reg - 16'h0001;
    end
  end

  // =====================================================
  // bit recovery
  serial_rx_pkg::rx_state_t state_reg;
  logic [3:0] phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] shift_reg;
  logic line_reg;
  logic [1:0] votes_reg;
  logic majority;
  logic char_done;
  logic char_framing;
  logic [8:0] char_data;
  logic [3:0] data_bits;

  assign data_bits = nine_sel ? 4'h9 : 4'h8;
  assign majority = votes_reg[1] & (votes_reg[0] | serial_receive_pin)
    | (votes_reg[1] ^ votes_reg[0]) & serial_receive_pin;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_reg <= 1'b1;
    end else begin
      line_reg <= serial_receive_pin;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= serial_rx_pkg::st_idle;
      phase_reg <= 4'h0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 9'h000;
      votes_reg <= 2'h0;
      char_done <= 1'b0;
      char_framing <= 1'b0;
      char_data <= 9'h000;
    end else begin
      char_done <= 1'b0;
      if (!rx_en) begin
        state_reg <= serial_rx_pkg::st_idle;
      end else begin
        case (state_reg)
          serial_rx_pkg::st_idle: begin
            if (line_reg && !serial_receive_pin) begin
              state_reg <= serial_rx_pkg::st_start;
              phase_reg <= 4'h0;
            end
          end
          serial_rx_pkg::st_start: begin
            if (tick) begin
              phase_reg <= phase_reg + 4'h1;
              if (phase_reg == serial_rx_pkg::half_bit) begin
                if (serial_receive_pin) begin
                  state_reg <= serial_rx_pkg::st_idle;
                end else begin
                  state_reg <= serial_rx_pkg::st_data;
                  // first data decision lands one full bit after start centre
                  phase_reg <= serial_rx_pkg::centre_late + 4'h1;
                  bit_cnt_reg <= 4'h0;
                end
              end
            end
          end
          serial_rx_pkg::st_data, serial_rx_pkg::st_stop: begin
            if (tick) begin
              phase_reg <= phase_reg + 4'h1;
              if (phase_reg == serial_rx_pkg::centre_early) begin
                votes_reg <= {serial_receive_pin, 1'b0};
              end else if (phase_reg == serial_rx_pkg::half_bit) begin
                votes_reg <= {votes_reg[1], serial_receive_pin};
              end else if (phase_reg == serial_rx_pkg::centre_late) begin
                if (state_reg == serial_rx_pkg::st_data) begin
                  shift_reg <= {majority, shift_reg[8:1]};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end else begin
                  char_done <= 1'b1;
                  char_framing <= ~majority;
                  char_data <= nine_sel ? shift_reg : {1'b0, shift_reg[8:1]};
                  state_reg <= serial_rx_pkg::st_idle;
                end
              end else if (phase_reg == serial_rx_pkg::oversample) begin
                if (state_reg == serial_rx_pkg::st_data && bit_cnt_reg == data_bits) begin
                  state_reg <= serial_rx_pkg::st_stop;
                end
              end
            end
          end
          default: state_reg <= serial_rx_pkg::st_idle;
        endcase
      end
    end
  end

  // =====================================================
  // two-entry fifo and overrun
  serial_rx_pkg::rx_entry_t fifo_mem [serial_rx_pkg::fifo_depth];
  logic rd_ptr_reg;
  logic wr_ptr_reg;
  logic [1:0] count_reg;
  logic overrun_reg;
  logic push;
  logic pop;
  serial_rx_pkg::rx_entry_t head;

  assign pop = data_pop && count_reg != 2'h0;
  assign push = char_done && !overrun_reg && count_reg != 2'h2
    && (!addr_det || char_data[8]);
  assign head = fifo_mem[rd_ptr_reg];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
    end else if (push) begin
      fifo_mem[wr_ptr_reg] <= {char_framing, char_data};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else if (!port_en) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overrun_reg <= 1'b0;
    end else if (!rx_en) begin
      overrun_reg <= 1'b0;
    end else if (char_done && count_reg == 2'h2 && !pop
      && (!addr_det || char_data[8])) begin
      overrun_reg <= 1'b1;
    end
  end

  // =====================================================
  // status and read data
  logic pending;
  logic framing_status;
  logic [7:0] status_view;

  assign pending = rx_en && count_reg != 2'h0;
  // port disable hides the tag at once, before the fifo clear lands
  assign framing_status = port_en && count_reg != 2'h0 && head.framing;
  assign receive_interrupt = pending && ie_reg[serial_rx_pkg::bit_rx_ie]
    && ie_reg[serial_rx_pkg::bit_periph_ie] && ie_reg[serial_rx_pkg::bit_global_ie];

  always_comb begin
    status_view = rcs_reg;
    status_view[serial_rx_pkg::bit_framing] = framing_status;
    status_view[serial_rx_pkg::bit_overrun] = overrun_reg;
    status_view[serial_rx_pkg::bit_ninth] = head.data[8] & (count_reg != 2'h0);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (!req.read) begin
      rdata <= 8'h00;
    end else if (req.addr == serial_rx_pkg::addr_rx_status) begin
      rdata <= status_view;
    end else if (req.addr == serial_rx_pkg::addr_rx_data) begin
      rdata <= head.data[7:0];
    end else if (req.addr == serial_rx_pkg::addr_tx_status) begin
      rdata <= txs_reg;
    end else if (req.addr == serial_rx_pkg::addr_baud_ctrl) begin
      rdata <= {1'b0, state_reg == serial_rx_pkg::st_idle, 2'h0, baud_reg[3], 3'h0};
    end else if (req.addr == serial_rx_pkg::addr_baud_low) begin
      rdata <= div_low_reg;
    end else if (req.addr == serial_rx_pkg::addr_baud_high) begin
      rdata <= div_high_reg;
    end else if (req.addr == serial_rx_pkg::addr_int_ctrl) begin
      rdata <= {4'h0, pending, ie_reg};
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : async_serial_receiver

// File: verification/serial_line_model.sv
`timescale 1ns/1ps
module serial_line_model #(
  parameter int bit_clocks = 32
) (
  // clock
  input wire logic clk,
  // serial line, driven high by the model when idle
  output logic line
);
  initial line = 1'b1;
  // ==========================
  // frame: start, data lsb first, stop, one idle bit
  task automatic send(input logic [8:0] data, input logic nine, input logic stop);
    @(posedge clk);
    line <= 1'b0;
    repeat (bit_clocks) @(posedge clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      line <= data[i];
      repeat (bit_clocks) @(posedge clk);
    end
    line <= stop;
    repeat (bit_clocks) @(posedge clk);
    line <= 1'b1;
    repeat (bit_clocks) @(posedge clk);
  endtask : send
  // short low pulse, shorter than half a bit
  task automatic glitch(input int len);
    @(posedge clk);
    line <= 1'b0;
    repeat (len) @(posedge clk);
    line <= 1'b1;
    repeat (bit_clocks * 2) @(posedge clk);
  endtask : glitch
endmodule : serial_line_model

// File: verification/async_serial_receiver_properties.sv
`timescale 1ns/1ps
module async_serial_receiver_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port, line, outputs
  input wire serial_rx_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic serial_receive_pin,
  input wire logic pin_serial_owned,
  input wire logic receive_interrupt
);
  logic [7:0] ctrl_reg;
  logic [2:0] ien_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================
  // shadows of software-written controls
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= 8'h00;
    end else if (req.write && req.addr == serial_rx_pkg::addr_rx_status) begin
      ctrl_reg <= req.wdata;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ien_reg <= 3'h0;
    end else if (req.write && req.addr == serial_rx_pkg::addr_int_ctrl) begin
      ien_reg <= req.wdata[2:0];
    end
  end
  // ==========================
  // properties
  a_rdata_idle: assert property (!req.read |=> rdata == 8'h00) else $error("rdata not zero without read");
  a_unmapped_zero: assert property (req.read && req.addr == 3'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_int_gated: assert property (receive_interrupt |-> ien_reg == 3'h7) else $error("interrupt without enables");
  a_int_port_off: assert property (!ctrl_reg[7] |-> !receive_interrupt) else $error("interrupt while off");
  a_pin_owned: assert property (pin_serial_owned == ctrl_reg[7]) else $error("pin ownership wrong");
  a_ctrl_readback: assert property (req.read && req.addr == serial_rx_pkg::addr_rx_status |=>
    (rdata & 8'hd8) == ($past(ctrl_reg) & 8'hd8)) else $error("control readback wrong");
  a_errors_cleared: assert property (req.read && req.addr == serial_rx_pkg::addr_rx_status && !ctrl_reg[7] |=>
    rdata[2:1] == 2'h0) else $error("error flags set while port off");
  a_pending_shown: assert property (req.read && req.addr == serial_rx_pkg::addr_int_ctrl |=>
    rdata[2:0] == $past(ien_reg) && ($past(ien_reg) != 3'h7 || rdata[3] == $past(receive_interrupt)))
    else $error("pending readback wrong");
endmodule : async_serial_receiver_checker

bind async_serial_receiver async_serial_receiver_checker checker_u (.clk(clk), .reset(reset), .req(req),
  .rdata(rdata), .serial_receive_pin(serial_receive_pin), .pin_serial_owned(pin_serial_owned),
  .receive_interrupt(receive_interrupt));

// File: verification/test_async_serial_receiver.sv
`timescale 1ns/1ps
module test_async_serial_receiver;
  logic clk;
  logic reset;
  serial_rx_pkg::reg_req_t req;
  logic [7:0] rdata;
  logic line;
  logic owned;
  logic irq;
  int miscompares;
  int num_checks;
  logic [8:0] d [0:3];
  logic st [0:1];

  always #4 clk = ~clk;
  async_serial_receiver dut_u (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
    .serial_receive_pin(line), .pin_serial_owned(owned), .receive_interrupt(irq));
  serial_line_model line_u (.clk(clk), .line(line));
  // ==========================
  // bus tasks and compares
  function automatic logic [7:0] status(input logic [7:0] c, input logic fe, input logic ov, input logic n);
    return (c & 8'hd8) | {5'h00, fe, ov, n};
  endfunction : status
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, write: 1'b1, read: 1'b0};
    @(posedge clk);
    req.write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clk);
    req.read <= 1'b0;
    @(negedge clk);
    chk(name, exp, rdata);
  endtask : rd
  task automatic rd_st(input logic [7:0] exp);
    rd(serial_rx_pkg::addr_rx_status, exp, "status");
  endtask : rd_st
  task automatic rd_dt(input logic [7:0] exp);
    rd(serial_rx_pkg::addr_rx_data, exp, "data");
  endtask : rd_dt
  task automatic rd_ie(input logic [7:0] exp);
    rd(serial_rx_pkg::addr_int_ctrl, exp, "int_ctrl");
  endtask : rd_ie
  task automatic wr_ctl(input logic [7:0] v);
    wr(serial_rx_pkg::addr_rx_status, v);
  endtask : wr_ctl
  task automatic chk_irq(input logic exp);
    @(negedge clk);
    chk("interrupt", {7'h00, exp}, {7'h00, irq});
  endtask : chk_irq
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  // ==========================
  // main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    req = '0;
    miscompares = 0;
    num_checks = 0;
    void'($urandom(32'h35254e41));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd_st(8'h00);
    rd_ie(8'h00);
    rd(3'h7, 8'h00, "unmapped");
    wr(serial_rx_pkg::addr_baud_low, 8'h01);
    wr_ctl(8'h90);
    @(negedge clk);
    chk("owned", 8'h01, {7'h00, owned});
    $display("test setup done");
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 2; k++) begin
        d[k] = 9'($urandom() & 32'hff);
        st[k] = (r == 0) ? 1'b0 : 1'($urandom());
        line_u.send(d[k], 1'b0, st[k]);
      end
      rd_ie(8'h08);
      for (int k = 0; k < 2; k++) begin
        rd_st(status(8'h90, !st[k], 1'b0, 1'b0));
        rd_dt(d[k][7:0]);
      end
      rd_ie(8'h00);
    end
    $display("test random characters done");
    line_u.glitch(4);
    rd_ie(8'h00);
    rd(serial_rx_pkg::addr_baud_ctrl, 8'h40, "idle");
    for (int k = 0; k < 4; k++) begin
      d[k] = 9'($urandom() & 32'hff);
      line_u.send(d[k], 1'b0, 1'b1);
    end
    rd_st(8'h92);
    rd_dt(d[0][7:0]);
    rd_st(8'h92);
    rd_dt(d[1][7:0]);
    rd_ie(8'h00);
    wr_ctl(8'h80);
    rd_st(8'h80);
    wr_ctl(8'h90);
    line_u.send(9'h0a5, 1'b0, 1'b0);
    wr_ctl(8'h80);
    rd_st(8'h84);
    wr_ctl(8'h00);
    rd_st(8'h00);
    wr_ctl(8'h90);
    $display("test overrun and enables done");
    wr(serial_rx_pkg::addr_int_ctrl, 8'h07);
    line_u.send(9'h03c, 1'b0, 1'b1);
    chk_irq(1'b1);
    wr(serial_rx_pkg::addr_int_ctrl, 8'h03);
    chk_irq(1'b0);
    wr(serial_rx_pkg::addr_int_ctrl, 8'h07);
    rd_dt(8'h3c);
    chk("interrupt", 8'h00, {7'h00, irq});
    wr_ctl(8'hd0);
    for (int k = 0; k < 2; k++) begin
      d[k] = {k[0], 8'($urandom())};
      line_u.send(d[k], 1'b1, 1'b1);
      rd_st(status(8'hd0, 1'b0, 1'b0, d[k][8]));
      rd_dt(d[k][7:0]);
    end
    wr_ctl(8'hd8);
    line_u.send(9'h055, 1'b1, 1'b1);
    line_u.send(9'h1c3, 1'b1, 1'b1);
    rd_st(8'hd9);
    rd_dt(8'hc3);
    rd_ie(8'h07);
    wr_ctl(8'hd0);
    line_u.send(9'h0aa, 1'b1, 1'b1);
    rd_st(8'hd0);
    rd_dt(8'haa);
    wr_ctl(8'hd8);
    line_u.send(9'h0bb, 1'b1, 1'b1);
    rd_ie(8'h07);
    $display("test nine bit and address done");
    wr_ctl(8'h90);
    wr(serial_rx_pkg::addr_tx_status, 8'h10);
    rd(serial_rx_pkg::addr_tx_status, 8'h10, "tx_status");
    line_u.send(9'h066, 1'b0, 1'b1);
    rd_ie(8'h07);
    wr(serial_rx_pkg::addr_tx_status, 8'h00);
    wr(serial_rx_pkg::addr_baud_ctrl, 8'h08);
    rd(serial_rx_pkg::addr_baud_ctrl, 8'h48, "baud_ctrl");
    line_u.send(9'h099, 1'b0, 1'b1);
    rd_st(8'h90);
    rd_dt(8'h99);
    $display("test modes done");
    stop_test();
  end
endmodule : test_async_serial_receiver
